//--- logic/parallel_slave_port.sv
// What this block does
// - mode select bit set turns the data port into an 8-bit slave port
// - master accesses the port asynchronously with active-low strobes, no clock
// - master writes land in rx_byte, master reads see the cpu-loaded latch: two separate 8-bit registers
// - in slave mode control pins zero, one, two are read, write, chip select
// - slave mode needs the three control pin direction bits set as inputs
// - write starts when chip select and write strobe first seen low
// - write ends when chip select or write strobe seen high
// - write end sets port event flag and input full flag
// - read drives latch onto pins and sets output full flag
// - cpu write during read drives new data without clearing output full
// - read end releases pins to input and sets port event flag
// - slave port only usable in microcontroller mode, no external memory
// - write while byte unread sets overflow flag, cleared only by software
// - mode select clear gives ordinary general purpose pin behaviour
// - input full means byte waiting; output full means master has started a read and cpu has not loaded a new byte since the read ended
`timescale 1ns/1ps
`default_nettype none
module parallel_slave_port
  import slave_port_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic slave_port_mode_select,
  input wire logic microcontroller_mode,
  input wire logic [2:0] control_pin_direction,
  input wire logic [WIDTH-1:0] data_port_pins_in,
  input wire logic [2:0] ctrl_pins_in,
  input wire logic [WIDTH-1:0] gpio_direction,
  input wire logic cpu_latch_write,
  input wire logic [WIDTH-1:0] cpu_latch_wdata,
  input wire logic cpu_data_read,
  input wire logic cpu_overflow_clear,
  input wire logic cpu_event_clear,
  output logic [WIDTH-1:0] data_port_pins_out,
  output logic [WIDTH-1:0] data_port_pins_oe,
  output logic [WIDTH-1:0] cpu_read_data,
  output port_status_t status
);

  // ==========================================================
  // input synchronisers
  logic [2:0] ctrl_meta;
  logic [2:0] ctrl_sync;
  logic [WIDTH-1:0] data_meta;
  logic [WIDTH-1:0] data_sync;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_meta <= 3'h7;
      ctrl_sync <= 3'h7;
      data_meta <= '0;
      data_sync <= '0;
    end else begin
      ctrl_meta <= ctrl_pins_in;
      ctrl_sync <= ctrl_meta;
      data_meta <= data_port_pins_in;
      data_sync <= data_meta;
    end
  end

  // ==========================================================
  // strobe decode
  logic active;
  logic wr_now;
  logic rd_now;
  logic wr_prev;
  logic rd_prev;
  logic wr_end;
  logic rd_end;

  assign active = slave_port_mode_select && microcontroller_mode
                  && (control_pin_direction == CTRL_DIR_INPUTS);
  assign wr_now = active && !ctrl_sync[CS_BIT] && !ctrl_sync[WR_BIT];
  assign rd_now = active && !ctrl_sync[CS_BIT] && !ctrl_sync[RD_BIT];
  assign wr_end = wr_prev && !wr_now;
  assign rd_end = rd_prev && !rd_now;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_prev <= 1'b0;
      rd_prev <= 1'b0;
    end else begin
      wr_prev <= wr_now;
      rd_prev <= rd_now;
    end
  end

  // ==========================================================
  // data latch
  logic [WIDTH-1:0] latch;
  logic [WIDTH-1:0] rx_byte;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latch <= LATCH_RESET;
    end else if (cpu_latch_write) begin
      latch <= cpu_latch_wdata;
    end
  end

  // received byte captured while strobes held; data seen through sync
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_byte <= LATCH_RESET;
    end else if (wr_now) begin
      rx_byte <= data_sync;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_read_data <= LATCH_RESET;
    end else if (active) begin
      cpu_read_data <= rx_byte;
    end else begin
      cpu_read_data <= data_sync;
    end
  end

  // ==========================================================
  // pin drive
  // drive on read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_port_pins_out <= LATCH_RESET;
      data_port_pins_oe <= '0;
    end else begin
      data_port_pins_out <= cpu_latch_write ? cpu_latch_wdata : latch;
      if (slave_port_mode_select) begin
        data_port_pins_oe <= rd_now ? '1 : '0;
      end else begin
        data_port_pins_oe <= ~gpio_direction;
      end
    end
  end

  // ==========================================================
  // status flags; hardware set wins over clear
  // one flop per flag keeps each flag to a single driving process
  logic input_full;
  logic output_full;
  logic overflow;
  logic port_event;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      input_full <= 1'b0;
    end else if (wr_end) begin
      input_full <= 1'b1;
    end else if (cpu_data_read) begin
      input_full <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow <= 1'b0;
    end else if (wr_end && input_full && !cpu_data_read) begin
      overflow <= 1'b1;
    end else if (cpu_overflow_clear) begin
      overflow <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      output_full <= 1'b0;
    end else if (rd_now && !rd_prev) begin
      output_full <= 1'b1;
    end else if (cpu_latch_write && !rd_now) begin
      output_full <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_event <= 1'b0;
    end else if (wr_end || rd_end) begin
      port_event <= 1'b1;
    end else if (cpu_event_clear) begin
      port_event <= 1'b0;
    end
  end

  // flags gathered into the status word; every bit is a flop
  assign status = '{input_full_flag: input_full,
                    output_full_flag: output_full,
                    input_overflow_flag: overflow,
                    port_event_flag: port_event};

  // ==========================================================
  // checks
  // event after write
  write_end_flags_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_end |=> status.port_event_flag && status.input_full_flag)
    else $error("write end did not set flags");

  read_release_a: assert property (@(posedge clk) disable iff (!arst_n)
    rd_end |=> data_port_pins_oe == '0 && status.port_event_flag)
    else $error("read end did not release pins");

  sequence read_start_s;
    !rd_prev ##1 rd_prev;
  endsequence
  read_drive_a: assert property (@(posedge clk) disable iff (!arst_n)
    read_start_s |-> status.output_full_flag && data_port_pins_oe == '1)
    else $error("read did not drive pins");

  read_update_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_now && cpu_latch_write) |=> data_port_pins_out == $past(cpu_latch_wdata))
    else $error("new data not driven");

  overflow_sticky_a: assert property (@(posedge clk) disable iff (!arst_n)
    status.input_overflow_flag && !cpu_overflow_clear |=> status.input_overflow_flag)
    else $error("overflow flag lost");

  full_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    cpu_data_read && !wr_end |=> !status.input_full_flag)
    else $error("input full not cleared");

  gpio_mode_a: assert property (@(posedge clk) disable iff (!arst_n)
    !slave_port_mode_select |=> data_port_pins_oe == ~$past(gpio_direction))
    else $error("gpio direction not followed");

  mode_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    !active && !wr_prev && !rd_prev |=> !$rose(input_full) && !$rose(output_full)
      && !$rose(port_event))
    else $error("strobe seen with port disabled");

  sync_delay_a: assert property (@(posedge clk) disable iff (!arst_n)
    1'b1 ##2 1'b1 |-> ctrl_sync == $past(ctrl_pins_in, 2))
    else $error("sync latency wrong");

endmodule : parallel_slave_port
`default_nettype wire

//--- logic/slave_port_pkg.sv
package slave_port_pkg;
  localparam int DATA_W = 8;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [2:0] CTRL_DIR_INPUTS = 3'h7;
  // control pin positions within the low port e pins
  localparam int RD_BIT = 0;
  localparam int WR_BIT = 1;
  localparam int CS_BIT = 2;

  typedef struct packed {
    logic input_full_flag;
    logic output_full_flag;
    logic input_overflow_flag;
    logic port_event_flag;
  } port_status_t;

  typedef struct packed {
    logic [DATA_W-1:0] out;
    logic [DATA_W-1:0] oe;
  } pin_drive_t;
endpackage : slave_port_pkg

//--- verification/ext_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// external master on the data port
module ext_master_model (
  input wire logic clk,
  input wire logic [7:0] dev_out,
  input wire logic [7:0] dev_oe,
  output logic [7:0] bus,
  output logic [2:0] ctrl_pins
);
  logic drv;
  logic [7:0] wdata;
  initial begin
    drv = 1'b0;
    wdata = 8'h00;
    ctrl_pins = 3'h7;
  end
  // released bus shows inverse, not a stale value
  always_comb bus = (dev_oe & dev_out) | (~dev_oe & (drv ? wdata : ~wdata));
  task automatic write_byte(input logic [7:0] d);
    @(negedge clk);
    wdata = d;
    drv = 1'b1;
    ctrl_pins = 3'h1;
    repeat (5) @(negedge clk);
    ctrl_pins = 3'h7;
    @(negedge clk);
    drv = 1'b0;
  endtask : write_byte
  task automatic read_level(input logic on);
    @(negedge clk);
    ctrl_pins = on ? 3'h2 : 3'h7;
  endtask : read_level
endmodule : ext_master_model
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import slave_port_pkg::*;
  logic clk, arst_n, mode, mcu, cpu_wr, cpu_rd, ovf_clr, ev_clr;
  logic [2:0] dir, ctrl;
  logic [7:0] gdir, wdat, bus, pout, poe, rdat;
  port_status_t st;
  int err_count, samples_checked;
  parallel_slave_port dut_u (.clk(clk), .arst_n(arst_n), .slave_port_mode_select(mode),
    .microcontroller_mode(mcu), .control_pin_direction(dir), .data_port_pins_in(bus),
    .ctrl_pins_in(ctrl), .gpio_direction(gdir), .cpu_latch_write(cpu_wr),
    .cpu_latch_wdata(wdat), .cpu_data_read(cpu_rd), .cpu_overflow_clear(ovf_clr),
    .cpu_event_clear(ev_clr), .data_port_pins_out(pout), .data_port_pins_oe(poe),
    .cpu_read_data(rdat), .status(st));
  ext_master_model master_u (.clk(clk), .dev_out(pout), .dev_oe(poe), .bus(bus),
    .ctrl_pins(ctrl));
  // ========================================
  // helpers
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic print_verdict();
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic cpu_load(input logic [7:0] d);
    @(negedge clk);
    wdat = d;
    cpu_wr = 1'b1;
    @(negedge clk);
    cpu_wr = 1'b0;
  endtask : cpu_load
  // ========================================
  // stimulus
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #3000000;
    err_count++;
    print_verdict();
  end
  initial begin
    {mode, mcu, cpu_wr, cpu_rd, ovf_clr, ev_clr} = 6'h30;
    dir = 3'h7;
    gdir = 8'h0F;
    wdat = 8'h00;
    err_count = 0;
    samples_checked = 0;
    arst_n = 1'b0;
    tick(6);
    arst_n = 1'b1;
    chk("status", {4'h0, st}, 8'h00);
    master_u.write_byte(8'hA5);
    tick(6);
    chk("status", {4'h0, st}, 8'h09);
    chk("rdata", rdat, 8'hA5);
    master_u.write_byte(8'h3C);
    tick(6);
    chk("status", {4'h0, st}, 8'h0B);
    chk("rdata", rdat, 8'h3C);
    cpu_rd = 1'b1;
    tick(1);
    cpu_rd = 1'b0;
    tick(2);
    chk("status", {4'h0, st}, 8'h03);
    {ovf_clr, ev_clr} = 2'h3;
    tick(1);
    {ovf_clr, ev_clr} = 2'h0;
    tick(2);
    chk("status", {4'h0, st}, 8'h00);
    cpu_load(8'h5A);
    master_u.read_level(1'b1);
    tick(6);
    chk("oe", poe, 8'hFF);
    chk("out", pout, 8'h5A);
    chk("status", {4'h0, st}, 8'h04);
    cpu_load(8'hC3);
    tick(3);
    chk("out", pout, 8'hC3);
    chk("status", {4'h0, st}, 8'h04);
    master_u.read_level(1'b0);
    tick(6);
    chk("oe", poe, 8'h00);
    chk("status", {4'h0, st}, 8'h05);
    cpu_load(8'h00);
    ev_clr = 1'b1;
    tick(1);
    ev_clr = 1'b0;
    // refused configurations: bad direction, external bus, gpio mode
    for (int i = 0; i < 3; i++) begin
      {mode, mcu, dir} = (i == 0) ? 5'h1E : (i == 1) ? 5'h17 : 5'h0F;
      master_u.write_byte(8'h77);
      tick(6);
      chk("status", {4'h0, st}, 8'h00);
      chk("oe", poe, mode ? 8'h00 : ~gdir);
      chk("rdata", rdat, mode ? 8'h88 : 8'h08);
    end
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
